// file: hw/dbt_consts.vh
/*
  constants of the dma burst and threshold control block: register
  offsets, field positions, reset values and fixed figures.
  assumes it is included by bare name from the dbt_ctrl design file.
*/
`ifndef DBT_CONSTS_VH
`define DBT_CONSTS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define DBT_OFS_ISO 12'h800
`define DBT_OFS_ASYNC 12'h808
`define DBT_OFS_LINK 12'h840
`define DBT_VENDOR_BIT 11
`define DBT_RST_ISO 32'h00007373
`define DBT_RST_ASYNC 32'h00107373
`define DBT_RST_LINK 32'h00000020
`define DBT_MASK_ISO 32'h0000ffff
`define DBT_MASK_ASYNC 32'h01ffffff

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define DBT_TX_BURST_HI 15
`define DBT_TX_BURST_LO 12
`define DBT_TX_THR_HI 11
`define DBT_TX_THR_LO 8
`define DBT_RX_BURST_HI 7
`define DBT_RX_BURST_LO 4
`define DBT_RX_THR_HI 3
`define DBT_RX_THR_LO 0
`define DBT_AT_LINK_HI 23
`define DBT_AT_LINK_LO 16
`define DBT_RETRY_MAX_BIT 24
`define DBT_AT_LINK_MAX 8'h20

// ----------------------------------------------------------------
// eeprom load indices
// ----------------------------------------------------------------
`define DBT_EE_ISO 2'h0
`define DBT_EE_ASYNC 2'h1
`define DBT_EE_LINK 2'h2

`endif

// file: hw/dbt_buf2.v
/*
  two-entry valid/ready buffer.
  assumes both sides on sys_clk; a stalled drain side never loses a word.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_buf2 #(
  parameter W = 34
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] slot0;
  reg [W-1:0] slot1;
  reg [1:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data = slot0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      count <= 2'h0;
      slot0 <= {W{1'b0}};
      slot1 <= {W{1'b0}};
    end
    else
    begin
      // slot0 is always the head; slot1 moves up on a pop
      if (pop)
        slot0 <= (count == 2'h2) ? slot1 : in_data;
      else if (push && count == 2'h0)
        slot0 <= in_data;
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop)))
        slot1 <= in_data;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// file: hw/dbt_req_gate.v
/*
  bus request and burst length decision for one dma engine.
  assumes level and limit come from same-clock fifo and descriptor logic.
  transmit: level is free fifo space, limit is data still to fetch.
  receive: level is data held, limit is room left in the host buffer.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_req_gate #(
  parameter IS_RX = 0
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [3:0] thr_n,
  input wire [3:0] burst_n,
  input wire [11:0] level,
  input wire [11:0] limit,
  input wire pkt_whole,
  input wire [7:0] cache_line,
  output reg req,
  output reg [11:0] burst
);
  function [11:0] quads16;
    input [3:0] n;
    begin
      quads16 = {4'h0, n, 4'h0} + 12'h010;
    end
  endfunction

  function [11:0] min12;
    input [11:0] a;
    input [11:0] b;
    begin
      min12 = (a < b) ? a : b;
    end
  endfunction

  wire [11:0] thr_q;
  wire [11:0] max_q;
  wire [11:0] raw;
  wire [11:0] cl;
  wire [11:0] trimmed;
  wire want;

  assign thr_q = quads16(thr_n);
  assign max_q = quads16(burst_n);
  assign raw = min12(max_q, min12(level, limit));
  assign cl = {4'h0, cache_line};
  // whole cache lines keep memory writes and reads line aligned in size
  assign trimmed = (cl != 12'h000 && raw >= cl) ? (raw - (raw % cl)) : raw;
  generate
    if (IS_RX)
    begin : g_rx
      assign want = (level >= thr_q) || (level > limit) || pkt_whole;
    end
    else
    begin : g_tx
      assign want = (level >= thr_q) || (limit < level);
    end
  endgenerate

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      req <= 1'b0;
      burst <= 12'h000;
    end
    else
    begin
      // nothing to move means no request, whatever the threshold
      req <= want && (trimmed != 12'h000);
      burst <= trimmed;
    end
  end
endmodule
`default_nettype wire

// file: hw/dbt_ctrl.v
/*
  vendor dma control registers and the decisions they steer: pci burst
  limits and fifo thresholds for the iso and async dma engines, plus the
  async transmit packet-ready signal to the link.
  assumes a bar0 memory decode that presents 12-bit window offsets, an
  eeprom reader on sys_clk that streams index/data pairs, and fifo and
  descriptor logic on sys_clk that reports levels in quadlets.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dbt_consts.vh"
module dbt_ctrl (
  input wire sys_clk,
  input wire sys_rst,
  input wire reg_sel,
  input wire [11:0] reg_addr,
  input wire [3:0] reg_be,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output wire reg_hit,
  output reg reg_ack,
  output reg [31:0] reg_rdata,
  input wire ee_valid,
  output wire ee_ready,
  input wire [1:0] ee_index,
  input wire [31:0] ee_data,
  input wire [11:0] it_space,
  input wire [11:0] it_remain,
  output wire it_req,
  output wire [11:0] it_burst,
  input wire [11:0] ir_data,
  input wire [11:0] ir_host_room,
  input wire ir_pkt_whole,
  output wire ir_req,
  output wire [11:0] ir_burst,
  input wire [11:0] at_space,
  input wire [11:0] at_remain,
  output wire at_req,
  output wire [11:0] at_burst,
  input wire [11:0] ar_data,
  input wire [11:0] ar_host_room,
  input wire ar_pkt_whole,
  output wire ar_req,
  output wire [11:0] ar_burst,
  input wire [7:0] cache_line,
  input wire [11:0] at_pkt_quads,
  input wire at_pkt_whole,
  input wire at_retry,
  output reg at_link_ready,
  output wire [31:0] low_level_link_features_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam [1:0] SLOT_ISO = 2'h0;
  localparam [1:0] SLOT_ASYNC = 2'h1;
  localparam [1:0] SLOT_LINK = 2'h2;
  localparam [1:0] SLOT_NONE = 2'h3;

  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] wdat;
    input [3:0] be;
    integer i;
    begin
      merge_be = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          merge_be[i*8 +: 8] = wdat[i*8 +: 8];
    end
  endfunction

  // exact offsets only: other upper-half addresses read zero and drop writes
  function [1:0] reg_slot;
    input [11:0] a;
    begin
      case (a)
        `DBT_OFS_ISO:
          reg_slot = SLOT_ISO;
        `DBT_OFS_ASYNC:
          reg_slot = SLOT_ASYNC;
        `DBT_OFS_LINK:
          reg_slot = SLOT_LINK;
        default:
          reg_slot = SLOT_NONE;
      endcase
    end
  endfunction

  // host writes and eeprom loads of the iso and async registers both pass here,
  // so neither path can set a bit there that has no meaning
  function [31:0] keep_bits;
    input [1:0] slot;
    input [31:0] v;
    begin
      case (slot)
        SLOT_ISO:
          keep_bits = v & `DBT_MASK_ISO;
        SLOT_ASYNC:
          keep_bits = v & `DBT_MASK_ASYNC;
        default:
          keep_bits = v;
      endcase
    end
  endfunction

  function [31:0] read_word;
    input [1:0] slot;
    input [31:0] iso_v;
    input [31:0] async_v;
    input [31:0] link_v;
    begin
      case (slot)
        SLOT_ISO:
          read_word = iso_v;
        SLOT_ASYNC:
          read_word = async_v;
        SLOT_LINK:
          read_word = link_v;
        default:
          read_word = 32'h00000000;
      endcase
    end
  endfunction

  // the link threshold counts 16*n, unlike the 16*(n+1) of the burst fields
  function [11:0] link_quads;
    input [7:0] n;
    begin
      link_quads = {n, 4'h0};
    end
  endfunction

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg [31:0] iso_dma_pci_control;
  reg [31:0] async_dma_pci_control;
  reg [31:0] low_level_link_features;
  reg [31:0] next_iso;
  reg [31:0] next_async;
  reg [31:0] next_link;

  wire vendor_hit;
  wire host_wr;
  wire host_rd;
  wire [1:0] acc_slot;
  wire ld_valid;
  wire ld_ready;
  wire [33:0] ld_word;
  wire [1:0] ld_index;
  wire [31:0] ld_data;

  // only the upper half of the window is ours; the lower half is left
  // unclaimed so the standard register decode answers there
  assign vendor_hit = reg_sel && reg_addr[`DBT_VENDOR_BIT];
  assign reg_hit = vendor_hit;
  assign host_wr = vendor_hit && reg_wr;
  assign host_rd = vendor_hit && reg_rd;
  assign acc_slot = reg_slot(reg_addr);

  // ----------------------------------------------------------------
  // eeprom load path
  // ----------------------------------------------------------------
  // a host write in the same cycle stalls the load, so the buffer holds
  // the eeprom word rather than dropping it
  dbt_buf2 #(
    .W(34)
  ) u_load_buf (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .in_valid(ee_valid),
    .in_ready(ee_ready),
    .in_data({ee_index, ee_data}),
    .out_valid(ld_valid),
    .out_ready(ld_ready),
    .out_data(ld_word)
  );

  assign ld_ready = !host_wr;
  assign ld_index = ld_word[33:32];
  assign ld_data = ld_word[31:0];

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  always @*
  begin
    next_iso = iso_dma_pci_control;
    next_async = async_dma_pci_control;
    next_link = low_level_link_features;
    if (host_wr)
    begin
      // no interlock against an enabled link: software keeps that order
      case (acc_slot)
        SLOT_ISO:
          next_iso = keep_bits(SLOT_ISO,
            merge_be(iso_dma_pci_control, reg_wdata, reg_be));
        SLOT_ASYNC:
          next_async = keep_bits(SLOT_ASYNC,
            merge_be(async_dma_pci_control, reg_wdata, reg_be));
        SLOT_LINK:
          next_link = merge_be(low_level_link_features, reg_wdata, reg_be);
        default:
          next_link = low_level_link_features;
      endcase
    end
    else if (ld_valid)
    begin
      case (ld_index)
        `DBT_EE_ISO:
          next_iso = keep_bits(SLOT_ISO, ld_data);
        `DBT_EE_ASYNC:
          next_async = keep_bits(SLOT_ASYNC, ld_data);
        `DBT_EE_LINK:
          next_link = ld_data;
        default:
          next_link = low_level_link_features;
      endcase
    end
  end

  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      iso_dma_pci_control <= `DBT_RST_ISO;
      async_dma_pci_control <= `DBT_RST_ASYNC;
      low_level_link_features <= `DBT_RST_LINK;
    end
    else
    begin
      iso_dma_pci_control <= next_iso;
      async_dma_pci_control <= next_async;
      low_level_link_features <= next_link;
    end
  end

  assign low_level_link_features_out = low_level_link_features;

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_ack <= 1'b0;
      reg_rdata <= 32'h00000000;
    end
    else
    begin
      reg_ack <= host_rd || host_wr;
      // rdata holds between reads, so a slow master may sample it late
      if (host_rd)
        reg_rdata <= read_word(acc_slot, iso_dma_pci_control, async_dma_pci_control,
          low_level_link_features);
    end
  end

  // ----------------------------------------------------------------
  // dma engine request gates
  // ----------------------------------------------------------------
  dbt_req_gate #(
    .IS_RX(0)
  ) u_it (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .thr_n(iso_dma_pci_control[`DBT_TX_THR_HI:`DBT_TX_THR_LO]),
    .burst_n(iso_dma_pci_control[`DBT_TX_BURST_HI:`DBT_TX_BURST_LO]),
    .level(it_space),
    .limit(it_remain),
    .pkt_whole(1'b0),
    .cache_line(cache_line),
    .req(it_req),
    .burst(it_burst)
  );

  dbt_req_gate #(
    .IS_RX(1)
  ) u_ir (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .thr_n(iso_dma_pci_control[`DBT_RX_THR_HI:`DBT_RX_THR_LO]),
    .burst_n(iso_dma_pci_control[`DBT_RX_BURST_HI:`DBT_RX_BURST_LO]),
    .level(ir_data),
    .limit(ir_host_room),
    .pkt_whole(ir_pkt_whole),
    .cache_line(cache_line),
    .req(ir_req),
    .burst(ir_burst)
  );

  dbt_req_gate #(
    .IS_RX(0)
  ) u_at (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .thr_n(async_dma_pci_control[`DBT_TX_THR_HI:`DBT_TX_THR_LO]),
    .burst_n(async_dma_pci_control[`DBT_TX_BURST_HI:`DBT_TX_BURST_LO]),
    .level(at_space),
    .limit(at_remain),
    .pkt_whole(1'b0),
    .cache_line(cache_line),
    .req(at_req),
    .burst(at_burst)
  );

  dbt_req_gate #(
    .IS_RX(1)
  ) u_ar (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .thr_n(async_dma_pci_control[`DBT_RX_THR_HI:`DBT_RX_THR_LO]),
    .burst_n(async_dma_pci_control[`DBT_RX_BURST_HI:`DBT_RX_BURST_LO]),
    .level(ar_data),
    .limit(ar_host_room),
    .pkt_whole(ar_pkt_whole),
    .cache_line(cache_line),
    .req(ar_req),
    .burst(ar_burst)
  );

  // ----------------------------------------------------------------
  // async transmit packet-ready to the link
  // ----------------------------------------------------------------
  wire [7:0] link_n_field;
  wire [7:0] link_n;
  wire [11:0] link_thr_q;

  assign link_n_field = async_dma_pci_control[`DBT_AT_LINK_HI:`DBT_AT_LINK_LO];
  // a retry that underran once waits for the deepest fill when enabled
  assign link_n = (at_retry && async_dma_pci_control[`DBT_RETRY_MAX_BIT])
    ? `DBT_AT_LINK_MAX : link_n_field;
  // values above the maximum are not clipped; 16*n still fits in 12 bits
  assign link_thr_q = link_quads(link_n);

  always @(posedge sys_clk)
  begin
    if (sys_rst)
      at_link_ready <= 1'b0;
    else
      at_link_ready <= (at_pkt_quads >= link_thr_q) || at_pkt_whole;
  end

endmodule
`default_nettype wire

// file: bench/dbt_ctrl_assertions.sv
/*
  port checker for dbt_ctrl, bound to the top module.
  assumes one clock domain, sys_clk, and synchronous active-high sys_rst.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_ctrl_assertions (
  input wire sys_clk,
  input wire sys_rst,
  input wire reg_sel,
  input wire [11:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_hit,
  input wire reg_ack,
  input wire [31:0] reg_rdata,
  input wire [11:0] it_space,
  input wire [11:0] it_remain,
  input wire it_req,
  input wire [11:0] it_burst,
  input wire [11:0] ir_data,
  input wire [11:0] ir_host_room,
  input wire ir_pkt_whole,
  input wire ir_req,
  input wire [7:0] cache_line,
  input wire at_pkt_whole,
  input wire at_link_ready
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  AST_HIT: assert property (reg_hit == (reg_sel && reg_addr[11]))
    else $error("reg_hit does not follow the upper window decode");
  AST_ACK: assert property (reg_sel && reg_addr[11] && (reg_wr || reg_rd) |=> reg_ack)
    else $error("claimed access not acknowledged next cycle");
  AST_ACK_CAUSE: assert property (reg_ack |->
    $past(reg_sel && reg_addr[11] && (reg_wr || reg_rd)))
    else $error("acknowledge without a claimed access");
  AST_ISO_RSVD: assert property (reg_ack && $past(reg_rd && reg_addr == 12'h800) |->
    reg_rdata[31:16] == 16'h0)
    else $error("iso register upper bits not zero");
  AST_ASY_RSVD: assert property (reg_ack && $past(reg_rd && reg_addr == 12'h808) |->
    reg_rdata[31:25] == 7'h0)
    else $error("async register upper bits not zero");
  AST_UNMAP: assert property (reg_ack && $past(reg_rd && reg_addr[11:8] != 4'h8) |->
    reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  AST_IT_BURST: assert property (it_req |->
    it_burst != 12'h0 && it_burst <= $past(it_space))
    else $error("iso transmit burst exceeds free space");
  AST_IT_EARLY: assert property (it_remain != 12'h0 && it_remain < it_space
    && cache_line == 8'h0 |=> it_req)
    else $error("iso transmit short remainder not requested");
  AST_IR_WHOLE: assert property (ir_pkt_whole && ir_data != 12'h0 && ir_host_room != 12'h0
    && cache_line == 8'h0 |=> ir_req)
    else $error("iso receive whole packet not requested");
  AST_LINK_WHOLE: assert property (at_pkt_whole |=> at_link_ready)
    else $error("whole packet not signalled to link");
endmodule
bind dbt_ctrl dbt_ctrl_assertions dbt_ctrl_assertions_inst (.sys_clk, .sys_rst, .reg_sel, .reg_addr,
  .reg_wr, .reg_rd, .reg_hit, .reg_ack, .reg_rdata, .it_space, .it_remain, .it_req, .it_burst,
  .ir_data, .ir_host_room, .ir_pkt_whole, .ir_req, .cache_line, .at_pkt_whole, .at_link_ready);
`default_nettype wire

// file: bench/dbt_ee_model.sv
/*
  serial eeprom load stream model feeding dbt_ctrl.
  assumes tasks are called right after a rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_ee_model (
  input wire logic clk,
  input wire logic ee_ready,
  output logic ee_valid,
  output logic [1:0] ee_index,
  output logic [31:0] ee_data
);
  // ----------------------------------------------------------------
  // word source
  // ----------------------------------------------------------------
  initial
  begin
    ee_valid = 1'b0;
    ee_index = 2'h0;
    ee_data = 32'h0;
  end
  // ready is read at the falling edge: it settles just after the rising edge
  task send(input logic [1:0] i, input logic [31:0] d);
    logic r;
    begin
      #1;
      ee_valid = 1'b1;
      ee_index = i;
      ee_data = d;
      do
      begin
        @(negedge clk);
        r = ee_ready;
        @(posedge clk);
      end
      while (r !== 1'b1);
    end
  endtask
  // released lines show the inverse so a stale word never looks valid
  task idle;
    begin
      #1;
      ee_valid = 1'b0;
      ee_index = ~ee_index;
      ee_data = ~ee_data;
    end
  endtask
endmodule
`default_nettype wire

// file: bench/dbt_ctrl_tb.sv
/*
  self-checking bench for dbt_ctrl: register access, eeprom load, gates.
  assumes dbt_ee_model as eeprom source and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
module dbt_ctrl_tb;
  logic sys_clk, sys_rst, reg_sel, reg_wr, reg_rd, reg_hit, reg_ack, ee_valid, ee_ready, full;
  logic ir_pkt_whole, ar_pkt_whole, at_pkt_whole, at_retry, it_req, ir_req, at_req, ar_req;
  logic at_link_ready;
  logic [1:0] ee_index;
  logic [3:0] reg_be;
  logic [7:0] cache_line;
  logic [11:0] reg_addr, it_space, it_remain, ir_data, ir_host_room, at_space, at_remain;
  logic [11:0] ar_data, ar_host_room, at_pkt_quads, it_burst, ir_burst, at_burst, ar_burst;
  logic [31:0] reg_wdata, reg_rdata, ee_data, llf;
  int mismatches, total_checks;

  dbt_ctrl dbt_ctrl_inst (.sys_clk, .sys_rst, .reg_sel, .reg_addr, .reg_be, .reg_wr, .reg_rd,
    .reg_wdata, .reg_hit, .reg_ack, .reg_rdata, .ee_valid, .ee_ready, .ee_index, .ee_data,
    .it_space, .it_remain, .it_req, .it_burst, .ir_data, .ir_host_room, .ir_pkt_whole, .ir_req,
    .ir_burst, .at_space, .at_remain, .at_req, .at_burst, .ar_data, .ar_host_room, .ar_pkt_whole,
    .ar_req, .ar_burst, .cache_line, .at_pkt_quads, .at_pkt_whole, .at_retry, .at_link_ready,
    .low_level_link_features_out(llf));
  dbt_ee_model dbt_ee_model_inst (.clk(sys_clk), .ee_ready, .ee_valid, .ee_index, .ee_data);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      total_checks++;
      if (got !== exp)
      begin
        mismatches++;
        $display("FAIL %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    begin
      @(posedge sys_clk);
      #1;
      {reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata, reg_be} = {1'b1, w, !w, a, d, be};
      @(posedge sys_clk);
      #1;
      {reg_sel, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h0, ~a, ~d};
      chk("reg_ack", 32'h1, reg_ack);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0, 4'h0);
      chk("reg_rdata", e, reg_rdata);
    end
  endtask
  task gate(input int k, input logic [11:0] lv, input logic [11:0] lm, input logic wh,
            input logic [12:0] e);
    logic [12:0] g;
    begin
      @(posedge sys_clk);
      #1;
      {it_space, it_remain, ir_data, ir_host_room} = 48'h0;
      {at_space, at_remain, ar_data, ar_host_room} = 48'h0;
      ir_pkt_whole = wh && k == 1;
      ar_pkt_whole = wh && k == 3;
      case (k)
        0: {it_space, it_remain} = {lv, lm};
        1: {ir_data, ir_host_room} = {lv, lm};
        2: {at_space, at_remain} = {lv, lm};
        default: {ar_data, ar_host_room} = {lv, lm};
      endcase
      @(posedge sys_clk);
      #1;
      g = k == 0 ? {it_req, it_burst} : k == 1 ? {ir_req, ir_burst} :
          k == 2 ? {at_req, at_burst} : {ar_req, ar_burst};
      chk("gate_req", {31'h0, e[12]}, {31'h0, g[12]});
      if (e[12])
        chk("gate_burst", {20'h0, e[11:0]}, {20'h0, g[11:0]});
    end
  endtask
  task lnk(input logic [11:0] q, input logic wh, input logic rt, input logic e);
    begin
      @(posedge sys_clk);
      #1;
      {at_pkt_quads, at_pkt_whole, at_retry} = {q, wh, rt};
      @(posedge sys_clk);
      #1;
      chk("at_link_ready", {31'h0, e}, {31'h0, at_link_ready});
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #100000;
    mismatches++;
    close_out;
  end
  initial
  begin
    {sys_rst, reg_sel, reg_wr, reg_rd, reg_addr, reg_be, reg_wdata} = {1'b1, 51'h0};
    {it_space, it_remain, ir_data, ir_host_room} = 48'h0;
    {at_space, at_remain, ar_data, ar_host_room, at_pkt_quads} = 60'h0;
    {ir_pkt_whole, ar_pkt_whole, at_pkt_whole, at_retry, cache_line, full} = 13'h0;
    repeat (10) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    rd(12'h800, 32'h0000_7373);
    rd(12'h808, 32'h0010_7373);
    rd(12'h840, 32'h0000_0020);
    @(posedge sys_clk);
    #1;
    {reg_sel, reg_rd, reg_addr} = {2'h3, 12'h7fc};
    #1;
    chk("reg_hit", 32'h0, reg_hit);
    @(posedge sys_clk);
    #1;
    {reg_sel, reg_rd} = 2'h0;
    chk("reg_ack", 32'h0, reg_ack);
    rd(12'hffc, 32'h0);
    // all-ones writes read back with reserved bits clear; byte enable 2 clears only bits 15:8
    bus(1'b1, 12'h800, 32'hffff_ffff, 4'hf);
    rd(12'h800, 32'h0000_ffff);
    bus(1'b1, 12'h808, 32'hffff_ffff, 4'hf);
    rd(12'h808, 32'h01ff_ffff);
    bus(1'b1, 12'h808, 32'h0, 4'h2);
    rd(12'h808, 32'h01ff_00ff);
    // host writes every cycle stall the load buffer until it refuses
    fork
      begin
        @(posedge sys_clk);
        #1;
        {reg_sel, reg_wr, reg_addr, reg_wdata, reg_be} = {2'h3, 12'h840, 32'h55, 4'hf};
        repeat (6) @(posedge sys_clk);
        #1;
        {reg_sel, reg_wr} = 2'h0;
      end
      begin
        @(posedge sys_clk);
        dbt_ee_model_inst.send(2'h0, 32'hdead_2031);
        dbt_ee_model_inst.send(2'h1, 32'hff02_f1e2);
        dbt_ee_model_inst.send(2'h2, 32'h0000_0021);
        dbt_ee_model_inst.send(2'h3, 32'hffff_ffff);
        dbt_ee_model_inst.idle;
      end
      repeat (5) @(negedge sys_clk) if (ee_ready === 1'b0) full = 1'b1;
    join
    repeat (4) @(posedge sys_clk);
    chk("ee_full", 32'h1, {31'h0, full});
    rd(12'h800, 32'h0000_2031);
    rd(12'h808, 32'h0102_f1e2);
    chk("link_features", 32'h21, llf);
    gate(0, 12'h00f, 12'h064, 1'b0, 13'h0000);
    gate(0, 12'h010, 12'h064, 1'b0, 13'h1010);
    gate(0, 12'h0c8, 12'h12c, 1'b0, 13'h1030);
    gate(0, 12'h00a, 12'h005, 1'b0, 13'h1005);
    gate(1, 12'h01f, 12'h064, 1'b0, 13'h0000);
    gate(1, 12'h020, 12'h064, 1'b0, 13'h1020);
    gate(1, 12'h0c8, 12'h1f4, 1'b0, 13'h1040);
    gate(1, 12'h014, 12'h00a, 1'b0, 13'h100a);
    gate(1, 12'h005, 12'h064, 1'b1, 13'h1005);
    gate(2, 12'h01f, 12'h3e8, 1'b0, 13'h0000);
    gate(2, 12'h020, 12'h3e8, 1'b0, 13'h1020);
    gate(2, 12'h12c, 12'h3e8, 1'b0, 13'h1100);
    gate(2, 12'h014, 12'h007, 1'b0, 13'h1007);
    gate(3, 12'h02f, 12'h1f4, 1'b0, 13'h0000);
    gate(3, 12'h030, 12'h1f4, 1'b0, 13'h1030);
    gate(3, 12'h190, 12'h1f4, 1'b0, 13'h10f0);
    gate(3, 12'h01e, 12'h00c, 1'b0, 13'h100c);
    gate(3, 12'h009, 12'h1f4, 1'b1, 13'h1009);
    cache_line = 8'h20;
    gate(3, 12'h064, 12'h1f4, 1'b0, 13'h1060);
    cache_line = 8'h0;
    lnk(12'h01f, 1'b0, 1'b0, 1'b0);
    lnk(12'h020, 1'b0, 1'b0, 1'b1);
    lnk(12'h1ff, 1'b0, 1'b1, 1'b0);
    lnk(12'h200, 1'b0, 1'b1, 1'b1);
    lnk(12'h001, 1'b1, 1'b1, 1'b1);
    bus(1'b1, 12'h808, 32'h0, 4'h8);
    lnk(12'h020, 1'b0, 1'b1, 1'b1);
    close_out;
  end
endmodule
`default_nettype wire
